// ### design/mwcs_pkg.sv
// package for the microwave count sequencer: constants and carrier types
// assumes a 40 MHz time base clock and a single synchronous reset
package mwcs_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned GATE_MS = 1;
    localparam int unsigned GATE_CYCLES = CLK_HZ / 1000 * GATE_MS;
    localparam logic [7:0] PRESCALE_MIN = 8'h02;
    localparam logic [7:0] PRESCALE_MAX = 8'h10;
    localparam logic [7:0] TRANSFER_MIN = 8'h01;
    localparam logic [7:0] TRANSFER_MAX = 8'hC8;
    localparam logic [7:0] COMB_FIRST = 8'h01;
    localparam logic [7:0] COMB_LAST = 8'h28;
    localparam int unsigned SETTLE_CYCLES = 64;
    localparam int unsigned FUND_HZ_MIN = 100000000;
    localparam int unsigned FUND_HZ_MAX = 500000000;
    localparam logic [7:0] COMB_MULT_DEFAULT = 8'h05;
    localparam logic [31:0] ACC_RESET = 32'h0000_0000;
    localparam logic [47:0] RESULT_RESET = 48'h0000_0000_0000;

    typedef enum logic [1:0] {
        MWCS_MODE_PRESCALE,
        MWCS_MODE_HETERODYNE,
        MWCS_MODE_TRANSFER
    } mwcs_mode_type;

    typedef struct packed {
        logic start;
        mwcs_mode_type mode;
        logic [7:0] ratio;
        logic stretch_gate;
        logic [7:0] comb_mult;
    } mwcs_cmd_type;

    typedef struct packed {
        logic done;
        logic no_signal;
        logic bad_ratio;
        logic [47:0] freq_hz;
        logic [7:0] comb_index;
    } mwcs_result_type;
endpackage

// ### design/mwcs_sequencer.sv
// microwave count sequencer: gate timing, decade accumulation, scaling,
// comb search and final frequency forming
// assumes the counted signal and detector/lock levels are asynchronous pins
// Operation
// - prescaled input divided by ratio 2..16
// - scale by multiplying count or stretching gate
// - gate flip-flop timed from time base
// - accumulate divided signal, scale, then display
// - comb index starts 1, steps until video
// - controller stores current comb harmonic index
// - result is video plus index times fundamental
// - fundamental is time base times multiplier
// - transfer counting starts only after lock
// - transfer scales by gate stretch 1..200
`timescale 1ns/10ps
`default_nettype none
module mwcs_sequencer (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire mwcs_pkg::mwcs_cmd_type cmd,
    input wire logic count_in,
    input wire logic video_present,
    input wire logic phase_locked,
    output logic [7:0] comb_select,
    output logic gate_open,
    output mwcs_pkg::mwcs_result_type result
);
    import mwcs_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEARCH,
        ST_SETTLE,
        ST_WAIT_LOCK,
        ST_GATE,
        ST_SCALE,
        ST_DONE
    } mwcs_state_type;

    typedef struct packed {
        mwcs_state_type state;
        logic [2:0] in_sync;
        logic [1:0] vid_sync;
        logic [1:0] lock_sync;
        logic gate_ff;
        logic [31:0] gate_left;
        logic [7:0] gate_reps;
        logic [31:0] decade_count_accumulator;
        logic [7:0] comb_index;
        logic [7:0] settle;
        mwcs_cmd_type cfg;
        mwcs_result_type res;
    } mwcs_core_type;

    mwcs_core_type core_reg;
    mwcs_core_type core_next;
    logic ratio_ok;
    logic in_rise;
    logic [47:0] fund_hz;
    logic [47:0] count_hz;
    logic [47:0] offset_hz;
    logic [47:0] ratio_hz;
    logic gate_last;
    logic search_last;

    // rising edge of the synchronised counted signal
    assign in_rise = core_reg.in_sync[1] & ~core_reg.in_sync[2];

    always_comb begin
        ratio_ok = 1'b1;
        unique case (cmd.mode)
            MWCS_MODE_PRESCALE: ratio_ok = cmd.ratio >= PRESCALE_MIN && cmd.ratio <= PRESCALE_MAX;
            MWCS_MODE_TRANSFER: ratio_ok = cmd.ratio >= TRANSFER_MIN && cmd.ratio <= TRANSFER_MAX;
            default: ratio_ok = 1'b1;
        endcase
    end

    assign fund_hz = 48'(CLK_HZ) * 48'(core_reg.cfg.comb_mult);

    // whole-millisecond gate, so count times 1000 is hertz
    assign count_hz = 48'(core_reg.decade_count_accumulator) * 48'(1000);
    // index times fundamental from the controller
    assign offset_hz = fund_hz * 48'(core_reg.comb_index);
    // multiplying path when the gate was not stretched
    assign ratio_hz = count_hz * 48'(core_reg.cfg.ratio);
    // last time base cycle of one gate slice
    assign gate_last = core_reg.gate_left == 32'h1;
    assign search_last = core_reg.comb_index == COMB_LAST;

    always_comb begin
        core_next = core_reg;
        // pins pass two flops; in_sync[2] is edge history only
        core_next.in_sync = {core_reg.in_sync[1:0], count_in};
        core_next.vid_sync = {core_reg.vid_sync[0], video_present};
        core_next.lock_sync = {core_reg.lock_sync[0], phase_locked};
        core_next.res.done = 1'b0;
        unique case (core_reg.state)
            ST_IDLE: begin
                // start taken only here; busy states ignore it
                if (cmd.start) begin
                    core_next.cfg = cmd;
                    core_next.res.no_signal = 1'b0;
                    core_next.res.bad_ratio = !ratio_ok;
                    core_next.decade_count_accumulator = ACC_RESET;
                    core_next.gate_reps = (cmd.mode != MWCS_MODE_HETERODYNE && cmd.stretch_gate)
                        ? cmd.ratio : 8'h01;
                    if (!ratio_ok) begin
                        core_next.res.done = 1'b1;
                    end else if (cmd.mode == MWCS_MODE_HETERODYNE) begin
                        core_next.comb_index = COMB_FIRST;
                        core_next.settle = 8'(SETTLE_CYCLES);
                        core_next.state = ST_SETTLE;
                    end else if (cmd.mode == MWCS_MODE_TRANSFER) begin
                        core_next.state = ST_WAIT_LOCK;
                    end else begin
                        core_next.gate_left = 32'(GATE_CYCLES);
                        core_next.state = ST_GATE;
                    end
                end
            end
            ST_SETTLE: begin
                core_next.settle = core_reg.settle - 8'h01;
                if (core_reg.settle == 8'h01) begin
                    core_next.state = ST_SEARCH;
                end
            end
            ST_SEARCH: begin
                if (core_reg.vid_sync[1]) begin
                    core_next.gate_left = 32'(GATE_CYCLES);
                    core_next.state = ST_GATE;
                end else if (search_last) begin
                    core_next.res.no_signal = 1'b1;
                    core_next.res.done = 1'b1;
                    core_next.state = ST_IDLE;
                end else begin
                    core_next.comb_index = core_reg.comb_index + 8'h01;
                    core_next.settle = 8'(SETTLE_CYCLES);
                    core_next.state = ST_SETTLE;
                end
            end
            ST_WAIT_LOCK: begin
                if (core_reg.lock_sync[1]) begin
                    core_next.gate_left = 32'(GATE_CYCLES);
                    core_next.state = ST_GATE;
                end
            end
            ST_GATE: begin
                // gate edges from time base count
                core_next.gate_ff = 1'b1;
                if (core_reg.gate_ff && in_rise) begin
                    core_next.decade_count_accumulator = core_reg.decade_count_accumulator + 32'h1;
                end
                if (core_reg.gate_ff) begin
                    core_next.gate_left = core_reg.gate_left - 32'h1;
                    if (gate_last) begin
                        if (core_reg.gate_reps == 8'h01) begin
                            core_next.gate_ff = 1'b0;
                            core_next.state = ST_SCALE;
                        end else begin
                            core_next.gate_reps = core_reg.gate_reps - 8'h01;
                            core_next.gate_left = 32'(GATE_CYCLES);
                        end
                    end
                end
            end
            ST_SCALE: begin
                if (core_reg.cfg.mode == MWCS_MODE_HETERODYNE) begin
                    core_next.res.freq_hz = count_hz + offset_hz;
                end else if (core_reg.cfg.stretch_gate) begin
                    // stretched gate already scaled the count
                    core_next.res.freq_hz = count_hz;
                end else begin
                    core_next.res.freq_hz = ratio_hz;
                end
                core_next.state = ST_DONE;
            end
            ST_DONE: begin
                core_next.res.done = 1'b1;
                core_next.state = ST_IDLE;
            end
            default: begin
                // unused state code: close the gate, fall back to idle
                core_next.gate_ff = 1'b0;
                core_next.state = ST_IDLE;
            end
        endcase
        // stored index reported in the result
        core_next.res.comb_index = core_next.comb_index;
    end

    // whole core state in one register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            core_reg <= '0;
            core_reg.state <= ST_IDLE;
            core_reg.res.freq_hz <= RESULT_RESET;
            core_reg.cfg.comb_mult <= COMB_MULT_DEFAULT;
        end else begin
            core_reg <= core_next;
        end
    end

    // outputs straight from the core register
    assign comb_select = core_reg.comb_index;
    assign gate_open = core_reg.gate_ff;
    assign result = core_reg.res;
endmodule
`default_nettype wire

// ### verification/mwcs_chk.sv
// port checker for mwcs_sequencer, bound below
// assumes cmd holds its mode through a measurement
`timescale 1ns/10ps
`default_nettype none
module mwcs_chk (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire mwcs_pkg::mwcs_cmd_type cmd,
    input wire logic video_present,
    input wire logic phase_locked,
    input wire logic [7:0] comb_select,
    input wire logic gate_open,
    input wire mwcs_pkg::mwcs_result_type result
);
    import mwcs_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    AST_DONE_PULSE: assert property (result.done |=> !result.done)
        else $error("done held over one cycle");
    AST_CLOSE_DONE: assert property ($fell(gate_open) && !$past(sys_rst)
        |-> ##[1:3] result.done) else $error("no done after gate close");
    AST_BAD_IDLE: assert property (result.bad_ratio |-> !gate_open)
        else $error("gate open on refused ratio");
    AST_NOSIG_IDLE: assert property (result.no_signal |-> !gate_open)
        else $error("gate open after failed search");
    AST_LOCK_FIRST: assert property ($rose(gate_open) && cmd.mode == MWCS_MODE_TRANSFER
        |-> $past(phase_locked, 2)) else $error("gate opened before lock");
    AST_VIDEO_FIRST: assert property ($rose(gate_open) && cmd.mode == MWCS_MODE_HETERODYNE
        |-> $past(video_present, 2)) else $error("gate opened without video");
    AST_IDX_RANGE: assert property (comb_select <= COMB_LAST)
        else $error("comb index past last line");
    AST_IDX_HOLD: assert property (gate_open |-> $stable(comb_select))
        else $error("comb index moved in gate");
    AST_RESET_ZERO: assert property ($past(sys_rst) |-> !gate_open && comb_select == 8'h00)
        else $error("outputs not cleared by reset");
endmodule
bind mwcs_sequencer mwcs_chk chk (.mclk(mclk), .sys_rst(sys_rst), .cmd(cmd),
    .video_present(video_present), .phase_locked(phase_locked),
    .comb_select(comb_select), .gate_open(gate_open), .result(result));
`default_nettype wire

// ### verification/mwcs_partner.sv
// stand-in for the down-converter: counted tone, detector, lock
// assumes the bench picks the video comb line and the lock moment
`timescale 1ns/10ps
`default_nettype none
module mwcs_partner (
    input wire logic [7:0] comb_select,
    input wire logic [7:0] video_line,
    input wire logic lock_en,
    output logic count_in,
    output logic video_present,
    output logic phase_locked
);
    // 5 MHz tone, phase free of the time base
    initial count_in = 1'b0;
    always #100 count_in = ~count_in;
    assign video_present = video_line != 8'h00 && comb_select == video_line;
    assign phase_locked = lock_en;
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// bench for mwcs_sequencer against an integer model
// assumes the partner tone gives 5000 counts per 1 ms gate
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import mwcs_pkg::*;
    logic mclk = 0, sys_rst = 1, lock_en = 0, gate_open, count_in, video_present, phase_locked;
    logic [7:0] video_line = 8'h00, comb_select;
    mwcs_cmd_type cmd = '0;
    mwcs_result_type result;
    int error_cnt = 0, checks = 0, n;
    int unsigned r, m, l;
    int bad [4] = '{1, 17, 0, 201};
    mwcs_sequencer uut (.mclk(mclk), .sys_rst(sys_rst), .cmd(cmd), .count_in(count_in),
        .video_present(video_present), .phase_locked(phase_locked),
        .comb_select(comb_select), .gate_open(gate_open), .result(result));
    mwcs_partner far (.comb_select(comb_select), .video_line(video_line), .lock_en(lock_en),
        .count_in(count_in), .video_present(video_present), .phase_locked(phase_locked));
    initial forever #12.5 mclk = ~mclk;
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp_freq(input logic [47:0] got, input longint exp, input longint tol);
        checks++;
        if ($isunknown(got) || (got > exp ? got - exp : exp - got) > tol) begin
            error_cnt++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        cmp_freq({47'h0, got}, longint'(exp), 0);
    endtask
    task automatic measure(input mwcs_mode_type md, input int unsigned ra, input int unsigned mu);
        cmd <= '{1'b1, md, ra[7:0], 1'b0, mu[7:0]};
        @(posedge mclk) #2 cmd.start <= 1'b0;
        for (n = 0; n < 50000 && result.done !== 1'b1; n++) @(posedge mclk) #2;
        if (n == 50000) begin
            error_cnt++;
            end_sim();
        end
        // one idle edge before the next start
        @(posedge mclk) #2;
    endtask
    initial begin
        r = $urandom(32'hD69E8255);
        repeat (5) @(posedge mclk);
        #2 sys_rst <= 0;
        foreach (bad[i]) begin
            measure(i < 2 ? MWCS_MODE_PRESCALE : MWCS_MODE_TRANSFER, bad[i], 5);
            cmp_flag(result.bad_ratio, 1'b1);
        end
        $display("refusal end");
        r = 2 + $urandom % 15;
        measure(MWCS_MODE_PRESCALE, r, 5);
        cmp_flag(result.bad_ratio, 1'b0);
        cmp_freq(result.freq_hz, 64'd5000000 * r, 2000 * r);
        $display("prescale end");
        m = 3 + $urandom % 10;
        l = 1 + $urandom % 4;
        video_line <= l[7:0];
        measure(MWCS_MODE_HETERODYNE, 0, m);
        cmp_freq(result.freq_hz, 64'd5000000 + 40000000 * m * l, 2000);
        cmp_freq({40'h0, result.comb_index}, l, 0);
        cmp_flag(result.no_signal, 1'b0);
        video_line <= 8'h00;
        measure(MWCS_MODE_HETERODYNE, 0, m);
        cmp_flag(result.no_signal, 1'b1);
        $display("heterodyne end");
        cmd <= '{1'b1, MWCS_MODE_TRANSFER, 8'h01, 1'b1, 8'h05};
        @(posedge mclk) #2 cmd.start <= 1'b0;
        repeat (200) @(posedge mclk);
        #2 cmp_flag(gate_open, 1'b0);
        lock_en <= 1'b1;
        for (n = 0; n < 10 && gate_open !== 1'b1; n++) @(posedge mclk) #2;
        cmp_flag(gate_open, 1'b1);
        if (gate_open !== 1'b1) end_sim();
        sys_rst <= 1'b1;
        @(posedge mclk) #2 sys_rst <= 1'b0;
        @(posedge mclk) #2 cmp_flag(gate_open, 1'b0);
        cmp_freq(result.freq_hz, RESULT_RESET, 0);
        cmp_freq({40'h0, comb_select}, 0, 0);
        $display("transfer end");
        end_sim();
    end
endmodule
`default_nettype wire
